// ### hdl/ssc_pkg.sv
// shared constants and carrier types of the serial command latch
// assumes one 10 MHz system clock; every pin enters asynchronously
package ssc_pkg;

   localparam int unsigned WORD_W = 16;
   localparam int unsigned GROUPS = 2;
   localparam int unsigned LEVEL_W = 4;
   localparam int unsigned DSEL_W = 2;
   localparam int unsigned ENTRY_W = 4;
   localparam int unsigned PCT_W = 7;

   // command word layout
   localparam int unsigned SCALE_LSB = 0;
   localparam int unsigned SCALE_W = 2;
   localparam int unsigned PB_DSEL_LSB = 2;
   localparam int unsigned PB_LEVEL_LSB = 4;
   localparam int unsigned PB_POL_BIT = 8;
   localparam int unsigned PA_DSEL_LSB = 9;
   localparam int unsigned PA_LEVEL_LSB = 11;
   localparam int unsigned PA_POL_BIT = 15;

   // scale code is {bit1, bit0}
   localparam logic [SCALE_W-1:0] SCALE_CODE_100 = 2'h3;
   localparam logic [SCALE_W-1:0] SCALE_CODE_85 = 2'h2;
   localparam logic [SCALE_W-1:0] SCALE_CODE_70 = 2'h1;
   localparam logic [PCT_W-1:0] PCT_100 = 7'h64;
   localparam logic [PCT_W-1:0] PCT_85 = 7'h55;
   localparam logic [PCT_W-1:0] PCT_70 = 7'h46;
   localparam logic [PCT_W-1:0] PCT_50 = 7'h32;

   localparam logic [LEVEL_W-1:0] LEVEL_OFF = 4'h0;
   localparam logic [WORD_W-1:0] WORD_CLEAR = 16'h0000;

   // decay table: entry n in bits 4n+3..4n, bit 3 of an entry = mixed, bits 2..0 = ratio
   localparam logic [WORD_W-1:0] TABLE_DEFAULT = 16'hFDA0;

   // synchroniser lane map
   localparam int unsigned SY_W = 12;
   localparam int unsigned SY_RESETN = 0;
   localparam int unsigned SY_SETUP = 1;
   localparam int unsigned SY_LOGIC_OK = 2;
   localparam int unsigned SY_MOTOR_OK = 3;
   localparam int unsigned SY_THERMAL = 4;
   localparam int unsigned SY_OVERCUR = 5;
   localparam int unsigned SY_LINK_BASE = 6;
   localparam int unsigned LINK_STRIDE = 3;
   localparam int unsigned LINK_CLK = 0;
   localparam int unsigned LINK_DATA = 1;
   localparam int unsigned LINK_STB = 2;

   typedef struct packed {
      logic serClk;
      logic serData;
      logic strobe;
   } ssc_link_t;

   typedef struct packed {
      logic [DSEL_W-1:0] decaySel;
      logic [LEVEL_W-1:0] level;
      logic polarity;
   } ssc_phase_cmd_t;

   typedef struct packed {
      ssc_phase_cmd_t cmd;
      logic [ENTRY_W-1:0] decayEntry;
      logic bridgePos;
      logic bridgeNeg;
   } ssc_phase_out_t;

   typedef struct packed {
      logic [PCT_W-1:0] scalePct;
      ssc_phase_out_t phA;
      ssc_phase_out_t phB;
   } ssc_group_out_t;

endpackage

// ### hdl/ssc_pin_sync.sv
// two-flop synchroniser bank with edge pulses taken after the second flop
// assumes asynchronous pins and a clock at least several times faster than them
module ssc_pin_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
      logic [W-1:0] prev;
   } ssc_sync_state_t;

   ssc_sync_state_t st_ff;
   ssc_sync_state_t nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      if (clkEn)
      begin
         nxt_st.meta = pinIn;
         nxt_st.stable = st_ff.meta;
         nxt_st.prev = st_ff.stable;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // edges only from the stable and previous stages, never from meta
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_edge
         assign level[i] = st_ff.stable[i];
         assign rise[i] = clkEn & st_ff.stable[i] & ~st_ff.prev[i];
         assign fall[i] = clkEn & ~st_ff.stable[i] & st_ff.prev[i];
      end
   endgenerate
endmodule // ssc_pin_sync

// ### hdl/ssc_decay_table.sv
// decay timing table of one channel group, four entries of four bits
// assumes load and clear come from the same clock domain
module ssc_decay_table (
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic load,
   input wire logic clear,
   input wire logic [ssc_pkg::WORD_W-1:0] loadWord,
   input wire logic [ssc_pkg::DSEL_W-1:0] selA,
   input wire logic [ssc_pkg::DSEL_W-1:0] selB,
   output logic [ssc_pkg::ENTRY_W-1:0] entryA,
   output logic [ssc_pkg::ENTRY_W-1:0] entryB
);
   import ssc_pkg::*;

   typedef struct packed {
      logic [WORD_W-1:0] entries;
   } ssc_table_state_t;

   ssc_table_state_t st_ff;
   ssc_table_state_t nxt_st;

   function automatic logic [ENTRY_W-1:0] pick(input logic [WORD_W-1:0] t, input logic [DSEL_W-1:0] s);
      pick = t[s*ENTRY_W +: ENTRY_W];
   endfunction

   always_comb
   begin
      nxt_st = st_ff;
      if (clkEn)
      begin
         if (clear)
         begin
            nxt_st.entries = TABLE_DEFAULT;
         end
         else if (load)
         begin
            nxt_st.entries = loadWord;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff.entries <= TABLE_DEFAULT;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign entryA = pick(st_ff.entries, selA);
   assign entryB = pick(st_ff.entries, selB);
endmodule // ssc_decay_table

// ### hdl/ssc_command_latch.sv
// serial command latch of a dual stepping-motor driver: two channel groups,
// each with its own shift register, command latch and decay table
// assumes all pins are asynchronous to clk and the serial clock is well below clk/4
//
// Functional notes
// - sixteen-bit word arrives bit 0 first
// - serial clock falling edge shifts data in
// - serial clock rising edge shifts nothing
// - latch pulse rise copies shift register
// - command latch otherwise holds its value
// - reset low: outputs off, pump halted, cleared
// - supply low clears; logic supply clears table
// - fault: outputs off, hold, until reset
// - thermal or overcurrent forces shutdown
// - overcurrent stays latched until reset asserted
// - scale bits pick 100/85/70/50 percent
// - per-phase decay select picks table entry
// - default table: slow, mixed ratio 2, mixed ratio 5, fast
// - four-bit level per phase, sixteen steps
// - zero level turns phase bridge off
// - polarity bit chooses output direction
// - second group identical and independent
// - setup high loads decay table instead
module ssc_command_latch (
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic resetN,
   input wire logic tableSetup,
   input wire logic logicSupplyOk,
   input wire logic motorSupplyOk,
   input wire logic thermalShutdown,
   input wire logic overcurrentShutdown,
   input wire ssc_pkg::ssc_link_t [ssc_pkg::GROUPS-1:0] link,
   output ssc_pkg::ssc_group_out_t [ssc_pkg::GROUPS-1:0] groupOut,
   output logic [ssc_pkg::GROUPS-1:0][ssc_pkg::WORD_W-1:0] cmdWord,
   output logic [ssc_pkg::GROUPS-1:0][ssc_pkg::WORD_W-1:0] shiftWord,
   output logic outputsOff,
   output logic chargePumpRun,
   output logic protLatched
);
   import ssc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [GROUPS-1:0][WORD_W-1:0] shiftReg;
      logic [GROUPS-1:0][WORD_W-1:0] cmdLatch;
      ssc_group_out_t [GROUPS-1:0] grpOut;
      logic protLatch;
      logic outOff;
      logic pumpRun;
   } ssc_top_state_t;

   ssc_top_state_t st_ff;
   ssc_top_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // decoding helpers

   function automatic ssc_phase_cmd_t phaseCmd(input logic [WORD_W-1:0] w, input logic phaseA);
      ssc_phase_cmd_t c;
      c = '0;
      if (phaseA)
      begin
         c.decaySel = w[PA_DSEL_LSB +: DSEL_W];
         c.level = w[PA_LEVEL_LSB +: LEVEL_W];
         c.polarity = w[PA_POL_BIT];
      end
      else
      begin
         c.decaySel = w[PB_DSEL_LSB +: DSEL_W];
         c.level = w[PB_LEVEL_LSB +: LEVEL_W];
         c.polarity = w[PB_POL_BIT];
      end
      phaseCmd = c;
   endfunction

   function automatic logic [PCT_W-1:0] scalePct(input logic [WORD_W-1:0] w);
      logic [SCALE_W-1:0] code;
      code = w[SCALE_LSB +: SCALE_W];
      case (code)
         SCALE_CODE_100: scalePct = PCT_100;
         SCALE_CODE_85: scalePct = PCT_85;
         SCALE_CODE_70: scalePct = PCT_70;
         default: scalePct = PCT_50;
      endcase
   endfunction

   function automatic ssc_phase_out_t phaseDrive(input ssc_phase_cmd_t c, input logic [ENTRY_W-1:0] entry,
                                                 input logic off);
      ssc_phase_out_t p;
      logic on;
      p = '0;
      p.cmd = c;
      p.decayEntry = entry;
      on = ~off & (c.level != LEVEL_OFF);
      p.bridgePos = on & c.polarity;
      p.bridgeNeg = on & ~c.polarity;
      phaseDrive = p;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [SY_W-1:0] syPins;
   logic [SY_W-1:0] syLevel;
   logic [SY_W-1:0] syRise;
   logic [SY_W-1:0] syFall;

   assign syPins[SY_RESETN] = resetN;
   assign syPins[SY_SETUP] = tableSetup;
   assign syPins[SY_LOGIC_OK] = logicSupplyOk;
   assign syPins[SY_MOTOR_OK] = motorSupplyOk;
   assign syPins[SY_THERMAL] = thermalShutdown;
   assign syPins[SY_OVERCUR] = overcurrentShutdown;

   genvar g;
   generate
      for (g = 0; g < GROUPS; g++)
      begin : g_link_pins
         assign syPins[SY_LINK_BASE + g*LINK_STRIDE + LINK_CLK] = link[g].serClk;
         assign syPins[SY_LINK_BASE + g*LINK_STRIDE + LINK_DATA] = link[g].serData;
         assign syPins[SY_LINK_BASE + g*LINK_STRIDE + LINK_STB] = link[g].strobe;
      end
   endgenerate

   // data and serial clock share one synchroniser depth, so the data seen at a
   // detected falling edge is the level the pin held at that edge
   ssc_pin_sync #(
      .W(SY_W)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .clkEn(clkEn),
      .pinIn(syPins),
      .level(syLevel),
      .rise(syRise),
      .fall(syFall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // global conditions

   logic resetActive;
   logic supplyFail;
   logic faultNow;
   logic accept;

   // a synchronised reset that reads low after power-up keeps the block off
   // until the pin is seen high, which is the safe direction
   assign resetActive = ~syLevel[SY_RESETN];
   assign supplyFail = ~syLevel[SY_LOGIC_OK] | ~syLevel[SY_MOTOR_OK];
   assign faultNow = syLevel[SY_THERMAL] | syLevel[SY_OVERCUR];
   // a fault seen one cycle before the latch sets must already stop shifting
   assign accept = ~resetActive & ~supplyFail & ~faultNow & ~st_ff.protLatch;

   ////////////////////////////////////////////////////////////////////////////
   // decay tables, one per group

   logic [GROUPS-1:0] tableLoad;
   logic [GROUPS-1:0][ENTRY_W-1:0] entryA;
   logic [GROUPS-1:0][ENTRY_W-1:0] entryB;
   ssc_phase_cmd_t [GROUPS-1:0] cmdA;
   ssc_phase_cmd_t [GROUPS-1:0] cmdB;

   generate
      for (g = 0; g < GROUPS; g++)
      begin : g_table
         assign cmdA[g] = phaseCmd(st_ff.cmdLatch[g], 1'b1);
         assign cmdB[g] = phaseCmd(st_ff.cmdLatch[g], 1'b0);
         // setup mode steers the latch pulse into the table instead of the command latch
         assign tableLoad[g] = accept & syLevel[SY_SETUP]
                               & syRise[SY_LINK_BASE + g*LINK_STRIDE + LINK_STB];

         ssc_decay_table u_table (
            .clk(clk),
            .rst(rst),
            .clkEn(clkEn),
            .load(tableLoad[g]),
            .clear(~syLevel[SY_LOGIC_OK]),
            .loadWord(st_ff.shiftReg[g]),
            .selA(cmdA[g].decaySel),
            .selB(cmdB[g].decaySel),
            .entryA(entryA[g]),
            .entryB(entryB[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      nxt_st = st_ff;
      if (clkEn)
      begin
         // set wins over clear so a fault during reset stays latched
         nxt_st.protLatch = faultNow | (st_ff.protLatch & ~resetActive);
         nxt_st.outOff = resetActive | supplyFail | faultNow | st_ff.protLatch;
         nxt_st.pumpRun = ~(resetActive | supplyFail | faultNow | st_ff.protLatch);

         for (int i = 0; i < GROUPS; i++)
         begin
            // each group runs off its own link pins plus the shared reset, supply, fault and setup pins
            if (resetActive | supplyFail)
            begin
               nxt_st.shiftReg[i] = WORD_CLEAR;
            end
            else if (accept & syFall[SY_LINK_BASE + i*LINK_STRIDE + LINK_CLK])
            begin
               // right shift: the first bit sent settles at bit 0 after sixteen edges
               nxt_st.shiftReg[i] = {syLevel[SY_LINK_BASE + i*LINK_STRIDE + LINK_DATA],
                                     st_ff.shiftReg[i][WORD_W-1:1]};
            end
            // a protection fault simply leaves the shift register as it was

            if (accept & ~syLevel[SY_SETUP] & syRise[SY_LINK_BASE + i*LINK_STRIDE + LINK_STB])
            begin
               nxt_st.cmdLatch[i] = st_ff.shiftReg[i];
            end

            nxt_st.grpOut[i].scalePct = scalePct(st_ff.cmdLatch[i]);
            nxt_st.grpOut[i].phA = phaseDrive(cmdA[i], entryA[i], st_ff.outOff);
            nxt_st.grpOut[i].phB = phaseDrive(cmdB[i], entryB[i], st_ff.outOff);
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff.shiftReg <= '0;
         st_ff.cmdLatch <= '0;
         st_ff.grpOut <= '0;
         st_ff.protLatch <= 1'b0;
         st_ff.outOff <= 1'b1;
         st_ff.pumpRun <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all from flops

   assign groupOut = st_ff.grpOut;
   assign cmdWord = st_ff.cmdLatch;
   assign shiftWord = st_ff.shiftReg;
   assign outputsOff = st_ff.outOff;
   assign chargePumpRun = st_ff.pumpRun;
   assign protLatched = st_ff.protLatch;
endmodule // ssc_command_latch

// ### sim/ssc_host_model.sv
// host side of one serial link: shifts a word bit 0 first, then pulses the latch
// assumes the bench clock; pins change just after its falling edge
module ssc_host_model (
   output ssc_pkg::ssc_link_t link,
   input wire logic clk
);
   timeunit 1ns;
   timeprecision 1ns;
   import ssc_pkg::*;
   // serial clock rests high between frames
   initial link = '{serClk: 1'b1, serData: 1'b0, strobe: 1'b0};
   task automatic waitClk(input int n);
      repeat (n) @(negedge clk);
   endtask
   ////////////////////////////////////////
   task automatic sendBits(input logic [WORD_W-1:0] w);
      for (int i = 0; i < WORD_W; i++)
      begin
         waitClk(2);
         link.serData = w[i];
         waitClk(2);
         link.serClk = 1'b0;
         waitClk(4);
         link.serClk = 1'b1;
         // hold time is over: invert so a late sample shows up
         link.serData = ~w[i];
      end
   endtask
   task automatic latch();
      waitClk(2);
      link.strobe = 1'b1;
      waitClk(4);
      link.strobe = 1'b0;
      waitClk(4);
   endtask
endmodule // ssc_host_model

// ### sim/ssc_cl_properties.sv
// port checker of the serial command latch, bound to its top module
// assumes clkEn high; pin effects show three clocks after the pin
module ssc_cl_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic resetN,
   input wire logic tableSetup,
   input wire logic logicSupplyOk,
   input wire logic motorSupplyOk,
   input wire logic thermalShutdown,
   input wire logic overcurrentShutdown,
   input wire ssc_pkg::ssc_link_t [ssc_pkg::GROUPS-1:0] link,
   input wire ssc_pkg::ssc_group_out_t [ssc_pkg::GROUPS-1:0] groupOut,
   input wire logic [ssc_pkg::GROUPS-1:0][ssc_pkg::WORD_W-1:0] cmdWord,
   input wire logic [ssc_pkg::GROUPS-1:0][ssc_pkg::WORD_W-1:0] shiftWord,
   input wire logic outputsOff,
   input wire logic chargePumpRun,
   input wire logic protLatched
);
   timeunit 1ns;
   timeprecision 1ns;
   import ssc_pkg::*;
   logic hold;
   logic ok;
   assign hold = resetN & logicSupplyOk & motorSupplyOk;
   assign ok = hold & !thermalShutdown & !overcurrentShutdown & !protLatched;
   function automatic logic [PCT_W-1:0] pct(input logic [SCALE_W-1:0] s);
      return (s == SCALE_CODE_100) ? PCT_100 : (s == SCALE_CODE_85) ? PCT_85 : (s == SCALE_CODE_70) ? PCT_70 : PCT_50;
   endfunction
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   chk_shift_in: assert property (ok && $fell(link[0].serClk)
      |-> ##3 shiftWord[0] == {$past(link[0].serData, 3), $past(shiftWord[0][15:1])}) else $error("shift wrong");
   chk_rise_hold: assert property (ok && $rose(link[0].serClk)
      |-> ##3 $stable(shiftWord[0])) else $error("rise shifted");
   chk_latch_copy: assert property (ok && !tableSetup && $rose(link[0].strobe)
      |-> ##3 cmdWord[0] == $past(shiftWord[0])) else $error("latch missed");
   chk_latch_hold: assert property ($changed(cmdWord[1])
      |-> $past(link[1].strobe, 3) && !$past(link[1].strobe, 4)) else $error("latch moved");
   chk_scale_map: assert property (!$past(rst)
      |-> groupOut[0].scalePct == pct($past(cmdWord[0][1:0]))) else $error("scale wrong");
   chk_level_off: assert property (groupOut[0].phA.cmd.level == LEVEL_OFF
      |-> !groupOut[0].phA.bridgePos && !groupOut[0].phA.bridgeNeg) else $error("bridge on");
   chk_reset_off: assert property (!resetN
      |-> ##3 outputsOff && !chargePumpRun && shiftWord == '0) else $error("reset ignored");
   chk_supply_clear: assert property (!(logicSupplyOk && motorSupplyOk)
      |-> ##3 outputsOff && !chargePumpRun && shiftWord == '0) else $error("supply ignored");
   chk_fault_trip: assert property (thermalShutdown || overcurrentShutdown
      |-> ##3 protLatched && outputsOff && !chargePumpRun) else $error("fault ignored");
   chk_prot_hold: assert property (protLatched && hold && $past(hold) && $past(hold, 2)
      |=> protLatched && $stable(shiftWord)) else $error("protection lost");
endmodule // ssc_cl_properties

bind ssc_command_latch ssc_cl_properties u_props (.clk(clk), .rst(rst), .resetN(resetN), .tableSetup(tableSetup),
   .logicSupplyOk(logicSupplyOk), .motorSupplyOk(motorSupplyOk), .thermalShutdown(thermalShutdown),
   .overcurrentShutdown(overcurrentShutdown), .link(link), .groupOut(groupOut), .cmdWord(cmdWord),
   .shiftWord(shiftWord), .outputsOff(outputsOff), .chargePumpRun(chargePumpRun), .protLatched(protLatched));

// ### sim/ssc_command_latch_test.sv
// self-checking bench of the serial command latch with two host models
// assumes clkEn tied high; waits follow the three and four clock latencies
module ssc_command_latch_test;
   timeunit 1ns;
   timeprecision 1ns;
   import ssc_pkg::*;
   localparam logic [WORD_W-1:0] CORNER [4] = '{16'h0000, 16'hFFFF, 16'h7FFE, 16'h80F5};
   logic clk, rst, resetN, tableSetup, logicSupplyOk, motorSupplyOk, thermalShutdown, overcurrentShutdown;
   ssc_link_t link0, link1;
   ssc_group_out_t [GROUPS-1:0] groupOut;
   logic [GROUPS-1:0][WORD_W-1:0] cmdWord, shiftWord;
   logic outputsOff, chargePumpRun, protLatched;
   logic [WORD_W-1:0] tbl [GROUPS];
   logic [WORD_W-1:0] cmdExp [GROUPS];
   logic [WORD_W-1:0] w;
   int errors, tests_run, seed;
   ssc_command_latch DUT (.clk(clk), .rst(rst), .clkEn(1'b1), .resetN(resetN), .tableSetup(tableSetup),
      .logicSupplyOk(logicSupplyOk), .motorSupplyOk(motorSupplyOk), .thermalShutdown(thermalShutdown),
      .overcurrentShutdown(overcurrentShutdown), .link({link1, link0}), .groupOut(groupOut), .cmdWord(cmdWord),
      .shiftWord(shiftWord), .outputsOff(outputsOff), .chargePumpRun(chargePumpRun), .protLatched(protLatched));
   ssc_host_model hostAB (.clk(clk), .link(link0));
   ssc_host_model hostCD (.clk(clk), .link(link1));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////
   function automatic ssc_phase_out_t phase(input logic [6:0] c, input logic [WORD_W-1:0] t, input logic off);
      ssc_phase_out_t p;
      p.cmd = c;
      p.decayEntry = t[4 * c[6:5] +: 4];
      p.bridgePos = !off && c[4:1] != LEVEL_OFF && c[0];
      p.bridgeNeg = !off && c[4:1] != LEVEL_OFF && !c[0];
      return p;
   endfunction
   function automatic ssc_group_out_t expOut(input logic [WORD_W-1:0] c, t, input logic off);
      ssc_group_out_t e;
      e.scalePct = (c[1:0] == 2'h3) ? PCT_100 : (c[1:0] == 2'h2) ? PCT_85 : (c[1:0] == 2'h1) ? PCT_70 : PCT_50;
      e.phA = phase({c[10:9], c[14:11], c[15]}, t, off);
      e.phB = phase({c[3:2], c[7:4], c[8]}, t, off);
      return e;
   endfunction
   task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic checkAll(input logic off);
      for (int g = 0; g < GROUPS; g++)
      begin
         check("cmdWord", 48'(cmdWord[g]), 48'(cmdExp[g]));
         check("groupOut", 48'(groupOut[g]), 48'(expOut(cmdExp[g], tbl[g], off)));
      end
   endtask
   task automatic flags(input logic [2:0] exp);
      check("flags", 48'({outputsOff, chargePumpRun, protLatched}), 48'(exp));
   endtask
   task automatic send(input int g, input logic [WORD_W-1:0] v, input logic doLatch);
      if (g == 0) hostAB.sendBits(v);
      else hostCD.sendBits(v);
      if (doLatch && g == 0) hostAB.latch();
      if (doLatch && g == 1) hostCD.latch();
      repeat (2) @(negedge clk);
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("BAD watchdog expected finish seen hang");
      conclude();
   end
   initial
   begin
      seed = 32'hB968;
      {errors, tests_run} = '0;
      {rst, resetN, tableSetup, thermalShutdown, overcurrentShutdown} = 5'h10;
      {logicSupplyOk, motorSupplyOk} = 2'h3;
      tbl = '{TABLE_DEFAULT, TABLE_DEFAULT};
      cmdExp = '{16'h0000, 16'h0000};
      repeat (6) @(negedge clk);
      rst = 1'b0;
      flags(3'h4);
      repeat (3) @(negedge clk);
      resetN = 1'b1;
      repeat (5) @(negedge clk);
      flags(3'h2);
      checkAll(1'b0);
      for (int i = 0; i < 10; i++)
      begin
         w = (i < 4) ? CORNER[i] : WORD_W'($random(seed));
         send(i % 2, w, 1'b1);
         cmdExp[i % 2] = w;
         check("shiftWord", 48'(shiftWord[i % 2]), 48'(w));
         checkAll(1'b0);
      end
      w = WORD_W'($random(seed));
      send(0, w, 1'b0);
      checkAll(1'b0);
      hostAB.latch();
      cmdExp[0] = w;
      checkAll(1'b0);
      tableSetup = 1'b1;
      repeat (3) @(negedge clk);
      w = WORD_W'($random(seed));
      send(1, w, 1'b1);
      tbl[1] = w;
      tableSetup = 1'b0;
      repeat (3) @(negedge clk);
      checkAll(1'b0);
      motorSupplyOk = 1'b0;
      repeat (5) @(negedge clk);
      check("shiftClear", 48'(shiftWord), 48'h0);
      flags(3'h4);
      checkAll(1'b1);
      motorSupplyOk = 1'b1;
      repeat (5) @(negedge clk);
      logicSupplyOk = 1'b0;
      repeat (5) @(negedge clk);
      tbl = '{TABLE_DEFAULT, TABLE_DEFAULT};
      checkAll(1'b1);
      logicSupplyOk = 1'b1;
      repeat (5) @(negedge clk);
      for (int f = 0; f < 2; f++)
      begin
         w = WORD_W'($random(seed));
         send(0, w, 1'b0);
         if (f == 0) thermalShutdown = 1'b1;
         else overcurrentShutdown = 1'b1;
         repeat (3) @(negedge clk);
         {thermalShutdown, overcurrentShutdown} = 2'h0;
         repeat (3) @(negedge clk);
         flags(3'h5);
         send(0, ~w, 1'b1);
         check("shiftHeld", 48'(shiftWord[0]), 48'(w));
         checkAll(1'b1);
         resetN = 1'b0;
         repeat (4) @(negedge clk);
         flags(3'h4);
         check("shiftReset", 48'(shiftWord[0]), 48'h0);
         resetN = 1'b1;
         repeat (5) @(negedge clk);
         flags(3'h2);
      end
      conclude();
   end
endmodule // ssc_command_latch_test
